// >>> rrc_pkg.sv
// constants, carrier types and shared functions of the rom/ram/io/timer combo
//
// Contract
// - A0-A9 and region select always address
// - port B bits 5,6: build-time chip select or pin
// - each chip select matched independently to pattern
// - 1024-byte ROM addressed by A0-A9 plus region
// - 64-byte RAM, A0-A5 byte, enabled on pattern match
// - direction 1: pin drives output latch bit
// - direction 0: pin input, driver off, pulled high
// - port write latches bus until next write
// - port read: pins for inputs, latch for outputs
// - port latch changes only on write
// - timer write loads 8-bit interval count
// - timer write takes prescale from A1:A0
// - read before flag returns remaining count
// - count zero at tick: flag set, wrap FF
// - after flag, count decrements every clock
// - timer access clears flag, unless set same cycle
// - timer access captures A3 as interrupt enable
// - enabled and flagged: port B bit 7 low
// - A2 high ports, A2 low timer, A1:A0 choose
// - reset clears port registers, bus, interrupt enable
// - data bus driven only in the cycle after a selected read
package rrc_pkg;

  // ---------------------------------------------------------------
  // register selects and prescale codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_PORT_A_DATA = 2'h0;
  localparam logic [1:0] SEL_PORT_A_DIR = 2'h1;
  localparam logic [1:0] SEL_PORT_B_DATA = 2'h2;
  localparam logic [1:0] SEL_PORT_B_DIR = 2'h3;
  localparam logic [1:0] PRE_DIV_1 = 2'h0;
  localparam logic [1:0] PRE_DIV_8 = 2'h1;
  localparam logic [1:0] PRE_DIV_64 = 2'h2;
  localparam logic [1:0] PRE_DIV_1024 = 2'h3;
  localparam logic [9:0] PRE_LAST_1 = 10'h000;
  localparam logic [9:0] PRE_LAST_8 = 10'h007;
  localparam logic [9:0] PRE_LAST_64 = 10'h03F;
  localparam logic [9:0] PRE_LAST_1024 = 10'h3FF;

  // ---------------------------------------------------------------
  // field positions, reset values, decode defaults
  // ---------------------------------------------------------------
  localparam int CS_ONE_BIT = 5;
  localparam int CS_TWO_BIT = 6;
  localparam int IRQ_PIN_BIT = 7;
  localparam int IRQ_EN_ADDR_BIT = 3;
  localparam int PORT_SEL_ADDR_BIT = 2;
  localparam logic [7:0] RESET_PORT = 8'h00;
  localparam logic [7:0] RESET_COUNT = 8'h00;
  localparam logic [9:0] RESET_PRE = 10'h000;
  localparam logic [7:0] COUNT_WRAP = 8'hFF;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [3:0] DEF_RAM_HIGH = 4'h0;
  localparam logic [3:0] DEF_IO_HIGH = 4'h1;
  localparam logic [7:0] DEF_ROM_SEED = 8'h5A;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {
    TM_PRESCALED = 1'b0,
    TM_FAST = 1'b1
  } rrc_tmode_t;

  typedef struct packed {
    logic valid;
    logic rw;
    logic region_select;
    logic [9:0] addr;
    logic [7:0] wdata;
  } rrc_bus_t;

  typedef struct packed {
    logic [63:0][7:0] ram;
    logic [7:0] dir_a;
    logic [7:0] latch_a;
    logic [7:0] dir_b;
    logic [7:0] latch_b;
    logic [7:0] count;
    logic [9:0] pre;
    logic [1:0] sel;
    logic flag;
    rrc_tmode_t mode;
    logic irq_en;
    logic [7:0] rd_data;
    logic rd_drive;
  } rrc_state_t;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [9:0] pre_last(input logic [1:0] sel);
    case (sel)
      PRE_DIV_1: pre_last = PRE_LAST_1;
      PRE_DIV_8: pre_last = PRE_LAST_8;
      PRE_DIV_64: pre_last = PRE_LAST_64;
      default: pre_last = PRE_LAST_1024;
    endcase
  endfunction

  // mask pattern stand-in; seed value is arbitrary
  function automatic logic [7:0] rom_byte(input logic [9:0] a,
                                          input logic [7:0] seed);
    rom_byte = a[7:0] ^ seed ^ {a[9:8], a[9:8], a[9:8], a[9:8]};
  endfunction

endpackage

// >>> rrc_combo.sv
// rom, ram, two i/o ports and interval timer behind the processor bus
`timescale 1ns/1ps
module rrc_combo #(
  parameter bit CS_ONE_USED = 1'b0,
  parameter bit CS_ONE_MATCH = 1'b0,
  parameter bit CS_TWO_USED = 1'b0,
  parameter bit CS_TWO_MATCH = 1'b0,
  parameter logic [3:0] RAM_HIGH = rrc_pkg::DEF_RAM_HIGH,
  parameter logic [3:0] IO_HIGH = rrc_pkg::DEF_IO_HIGH,
  parameter logic [7:0] ROM_SEED = rrc_pkg::DEF_ROM_SEED
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input rrc_pkg::rrc_bus_t cpu,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] port_a_pins_in,
  output logic [7:0] port_a_pins_out,
  output logic [7:0] port_a_pins_oe,
  input wire logic [7:0] port_b_pins_in,
  output logic [7:0] port_b_pins_out,
  output logic [7:0] port_b_pins_oe
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  rrc_pkg::rrc_state_t st;
  rrc_pkg::rrc_state_t next_st;
  logic port_b_bit5_option;
  logic port_b_bit6_option;
  logic chip_select_one;
  logic chip_select_two;
  logic cs_ok;
  logic rom_hit;
  logic ram_hit;
  logic io_hit;
  logic port_hit;
  logic timer_hit;
  logic timer_wr;
  logic tick;
  logic irq_set;
  logic [7:0] port_a_view;
  logic [7:0] port_b_view;

  assign port_b_bit5_option = port_b_pins_in[rrc_pkg::CS_ONE_BIT];
  assign port_b_bit6_option = port_b_pins_in[rrc_pkg::CS_TWO_BIT];
  // an unused select never gates the chip
  assign chip_select_one = !CS_ONE_USED ||
                           (port_b_bit5_option == CS_ONE_MATCH);
  assign chip_select_two = !CS_TWO_USED ||
                           (port_b_bit6_option == CS_TWO_MATCH);
  assign cs_ok = cpu.valid && chip_select_one && chip_select_two;
  assign rom_hit = cs_ok && cpu.region_select;
  assign ram_hit = cs_ok && !cpu.region_select &&
                   (cpu.addr[9:6] == RAM_HIGH);
  assign io_hit = cs_ok && !cpu.region_select &&
                  (cpu.addr[9:6] == IO_HIGH);
  assign port_hit = io_hit && cpu.addr[rrc_pkg::PORT_SEL_ADDR_BIT];
  assign timer_hit = io_hit && !cpu.addr[rrc_pkg::PORT_SEL_ADDR_BIT];
  assign timer_wr = timer_hit && !cpu.rw;

  // ---------------------------------------------------------------
  // timer tick
  // ---------------------------------------------------------------
  assign tick = (st.mode == rrc_pkg::TM_FAST) ||
                (st.pre == rrc_pkg::pre_last(st.sel));
  assign irq_set = !timer_wr && tick &&
                   (st.count == rrc_pkg::COUNT_ZERO);

  // pins read for inputs, latch for outputs
  assign port_a_view = (port_a_pins_in & ~st.dir_a) |
                       (st.latch_a & st.dir_a);
  assign port_b_view = (port_b_pins_in & ~st.dir_b) |
                       (st.latch_b & st.dir_b);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rd_drive = 1'b0;
    // prescaler free-runs and restarts after its last count
    if (tick) begin
      next_st.pre = rrc_pkg::RESET_PRE;
    end else begin
      next_st.pre = st.pre + 10'h001;
    end
    if (tick) begin
      if (st.count == rrc_pkg::COUNT_ZERO) begin
        next_st.flag = 1'b1;
        next_st.mode = rrc_pkg::TM_FAST;
        next_st.count = rrc_pkg::COUNT_WRAP;
      end else begin
        next_st.count = st.count - 8'h01;
      end
    end
    if (timer_hit) begin
      next_st.irq_en = cpu.addr[rrc_pkg::IRQ_EN_ADDR_BIT];
      // set wins over clear in the same cycle
      if (!irq_set) begin
        next_st.flag = 1'b0;
      end
    end
    if (timer_wr) begin
      next_st.count = cpu.wdata;
      next_st.sel = cpu.addr[1:0];
      next_st.pre = rrc_pkg::RESET_PRE;
      next_st.mode = rrc_pkg::TM_PRESCALED;
    end
    if (ram_hit && !cpu.rw) begin
      next_st.ram[cpu.addr[5:0]] = cpu.wdata;
    end
    if (port_hit && !cpu.rw) begin
      case (cpu.addr[1:0])
        rrc_pkg::SEL_PORT_A_DATA: next_st.latch_a = cpu.wdata;
        rrc_pkg::SEL_PORT_A_DIR: next_st.dir_a = cpu.wdata;
        rrc_pkg::SEL_PORT_B_DATA: next_st.latch_b = cpu.wdata;
        rrc_pkg::SEL_PORT_B_DIR: next_st.dir_b = cpu.wdata;
        default: next_st.latch_a = st.latch_a;
      endcase
    end
    // read data registered, bus driven the following cycle
    if (cpu.rw && (rom_hit || ram_hit || io_hit)) begin
      next_st.rd_drive = 1'b1;
      if (rom_hit) begin
        next_st.rd_data = rrc_pkg::rom_byte(cpu.addr, ROM_SEED);
      end else if (ram_hit) begin
        next_st.rd_data = st.ram[cpu.addr[5:0]];
      end else if (timer_hit) begin
        next_st.rd_data = st.count;
      end else begin
        case (cpu.addr[1:0])
          rrc_pkg::SEL_PORT_A_DATA: next_st.rd_data = port_a_view;
          rrc_pkg::SEL_PORT_A_DIR: next_st.rd_data = st.dir_a;
          rrc_pkg::SEL_PORT_B_DATA: next_st.rd_data = port_b_view;
          rrc_pkg::SEL_PORT_B_DIR: next_st.rd_data = st.dir_b;
          default: next_st.rd_data = st.rd_data;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st <= next_st;
      st.dir_a <= rrc_pkg::RESET_PORT;
      st.latch_a <= rrc_pkg::RESET_PORT;
      st.dir_b <= rrc_pkg::RESET_PORT;
      st.latch_b <= rrc_pkg::RESET_PORT;
      st.count <= rrc_pkg::RESET_COUNT;
      st.pre <= rrc_pkg::RESET_PRE;
      st.sel <= rrc_pkg::PRE_DIV_1;
      st.flag <= 1'b0;
      st.mode <= rrc_pkg::TM_PRESCALED;
      st.irq_en <= 1'b0;
      st.rd_data <= rrc_pkg::RESET_PORT;
      st.rd_drive <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // pins and bus
  // ---------------------------------------------------------------
  assign data_out = st.rd_data;
  assign data_oe = st.rd_drive;
  assign port_a_pins_out = st.latch_a;
  assign port_a_pins_oe = st.dir_a;

  always_comb begin
    port_b_pins_out = st.latch_b;
    port_b_pins_oe = st.dir_b;
    if (CS_ONE_USED) begin
      port_b_pins_oe[rrc_pkg::CS_ONE_BIT] = 1'b0;
    end
    if (CS_TWO_USED) begin
      port_b_pins_oe[rrc_pkg::CS_TWO_BIT] = 1'b0;
    end
    // open-drain pull-down; software keeps the bit an input
    if (st.irq_en && st.flag) begin
      port_b_pins_out[rrc_pkg::IRQ_PIN_BIT] = 1'b0;
      port_b_pins_oe[rrc_pkg::IRQ_PIN_BIT] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_read_drives_bus: assert property (
    cpu.rw && (rom_hit || ram_hit || io_hit) |=> data_oe)
    else $error("selected read did not drive the bus");

  a_bus_stays_off: assert property (
    !(cpu.valid && cpu.rw) |=> !data_oe)
    else $error("bus driven without a read");

  a_port_read_mix: assert property (
    port_hit && cpu.rw && cpu.addr[1:0] == rrc_pkg::SEL_PORT_A_DATA
    |=> data_out == (($past(port_a_pins_in) & ~st.dir_a) |
                     (st.latch_a & st.dir_a)))
    else $error("port read mixes pins and latch wrongly");

  a_latch_held: assert property (
    !(port_hit && !cpu.rw) |=> $stable(st.latch_a) && $stable(st.latch_b))
    else $error("port latch changed without a write");

  a_dir_drives: assert property (
    port_hit && !cpu.rw && cpu.addr[1:0] == rrc_pkg::SEL_PORT_A_DIR
    |=> port_a_pins_oe == $past(cpu.wdata))
    else $error("direction write not seen on enables");

  a_timer_load: assert property (
    timer_wr |=> st.count == $past(cpu.wdata) && !st.flag)
    else $error("timer write did not load count");

  a_prescale_eight: assert property (
    timer_wr && cpu.addr[1:0] == rrc_pkg::PRE_DIV_8 &&
    cpu.wdata == 8'h05 ##1 !timer_wr [*8] |=> st.count == 8'h04)
    else $error("divide by eight interval wrong");

  a_wrap_flag: assert property (
    irq_set |=> st.count == rrc_pkg::COUNT_WRAP && st.flag)
    else $error("zero count did not wrap and flag");

  a_fast_count: assert property (
    st.mode == rrc_pkg::TM_FAST && !timer_wr && st.count != 8'h00
    |=> st.count == $past(st.count) - 8'h01)
    else $error("fast count did not step each clock");

  a_flag_clear: assert property (
    st.flag && timer_hit && !irq_set |=> !st.flag)
    else $error("timer access did not clear flag");

  a_irq_enable: assert property (
    timer_hit |=> st.irq_en == $past(cpu.addr[3]))
    else $error("interrupt enable not taken from A3");

  a_irq_pin_low: assert property (
    st.irq_en && st.flag |-> port_b_pins_oe[7] && !port_b_pins_out[7])
    else $error("interrupt not driven low on port B bit 7");

  a_reset_clears: assert property (@(posedge sys_clk)
    disable iff (1'b0)
    !rst_b |=> st.dir_a == 8'h00 && st.dir_b == 8'h00 && !data_oe &&
               !st.irq_en)
    else $error("reset left ports or bus active");

  c_timer_irq: cover property (timer_wr ##[1:300] irq_set);
  c_port_write_read: cover property (
    port_hit && !cpu.rw ##1 port_hit && cpu.rw);
  c_ram_read: cover property (ram_hit && cpu.rw);
  c_same_cycle_read: cover property (irq_set && timer_hit && cpu.rw);

endmodule

// >>> rrc_cpu_model.sv
// processor-side bus model issuing single-cycle accesses
`timescale 1ns/1ps
module rrc_cpu_model (
  input wire logic sys_clk,
  output rrc_pkg::rrc_bus_t cpu
);
  // ---------------------------------------------------------------
  // access driver
  // ---------------------------------------------------------------
  // accepted read range, low byte in upper half
  logic [15:0] exp_q[$];

  initial begin
    cpu = '0;
  end

  // one access; a released bus shows inverted values, not the last ones
  task automatic access(input logic rw, input logic rs,
                        input logic [9:0] addr, input logic [7:0] wdata,
                        input logic [7:0] lo, input logic [7:0] hi,
                        input bit answer);
    @(negedge sys_clk);
    cpu.valid <= 1'b1;
    cpu.rw <= rw;
    cpu.region_select <= rs;
    cpu.addr <= addr;
    cpu.wdata <= wdata;
    if (rw && answer) begin
      exp_q.push_back({lo, hi});
    end
    @(negedge sys_clk);
    cpu.valid <= 1'b0;
    cpu.rw <= ~rw;
    cpu.region_select <= ~rs;
    cpu.addr <= ~addr;
    cpu.wdata <= ~wdata;
  endtask
endmodule

// >>> tb_rrc_combo.sv
// self-checking bench of the rom/ram/io/timer combo
`timescale 1ns/1ps
module tb_rrc_combo;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  rrc_pkg::rrc_bus_t cpu;
  logic [7:0] data_out, a_in, a_out, a_oe, b_in, b_out, b_oe;
  logic data_oe;
  logic [7:0] ext_a = 8'h00, ext_b = 8'h00, en_a = 8'h00, en_b = 8'h00;
  logic [7:0] d, l, e, en, x, v;
  logic [9:0] ra;
  logic [15:0] ent;
  int n_fail = 0, checks = 0, cyc = 0, t, n, p;

  always #2.5 sys_clk = ~sys_clk;

  // undriven pins float high through the pull-up
  assign a_in = (a_oe & a_out) | (~a_oe & (~en_a | ext_a));
  assign b_in = (b_oe & b_out) | (~b_oe & (~en_b | ext_b));

  rrc_cpu_model cpu_m (.sys_clk(sys_clk), .cpu(cpu));

  rrc_combo uut (.sys_clk(sys_clk), .rst_b(rst_b), .cpu(cpu),
    .data_out(data_out), .data_oe(data_oe),
    .port_a_pins_in(a_in), .port_a_pins_out(a_out),
    .port_a_pins_oe(a_oe), .port_b_pins_in(b_in),
    .port_b_pins_out(b_out), .port_b_pins_oe(b_oe));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: pin got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic rs, input logic [9:0] a,
                    input logic [7:0] lo_v, input logic [7:0] hi_v);
    cpu_m.access(1'b1, rs, a, 8'h00, lo_v, hi_v, 1'b1);
  endtask

  task automatic wr(input logic rs, input logic [9:0] a,
                    input logic [7:0] w);
    cpu_m.access(1'b0, rs, a, w, 8'h00, 8'h00, 1'b0);
  endtask

  function automatic logic [9:0] pa(input logic [1:0] sel);
    pa = {rrc_pkg::DEF_IO_HIGH, 2'b00, 1'b0, 1'b1, sel};
  endfunction

  function automatic logic [9:0] ta(input logic ie, input logic [1:0] sel);
    ta = {rrc_pkg::DEF_IO_HIGH, 2'b00, ie, 1'b0, sel};
  endfunction

  // ---------------------------------------------------------------
  // read monitor and timeout
  // ---------------------------------------------------------------
  always @(negedge sys_clk) begin
    if (data_oe === 1'b1) begin
      checks++;
      if (cpu_m.exp_q.size() == 0) begin
        n_fail++;
        $display("Error %0t: bus driven with no read", $time);
      end else begin
        ent = cpu_m.exp_q.pop_front();
        if ((data_out >= ent[15:8] &&
             data_out <= ent[7:0]) !== 1'b1) begin
          n_fail++;
          $display("Error %0t: read %h not in %h..%h", $time, data_out,
                   ent[15:8], ent[7:0]);
        end
      end
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hAF464BC6));
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    chk(a_oe | b_oe, 8'h00);
    rd(1'b0, pa(rrc_pkg::SEL_PORT_A_DIR), 8'h00, 8'h00);
    rd(1'b0, pa(rrc_pkg::SEL_PORT_B_DATA), 8'hFF, 8'hFF);
    for (int q = 0; q < 8; q++) begin
      d = 8'($urandom);
      l = 8'($urandom);
      e = 8'($urandom);
      en = 8'($urandom);
      if (q[2]) begin
        d[7] = 1'b0;
        ext_b = e;
        en_b = en;
      end else begin
        ext_a = e;
        en_a = en;
      end
      x = (d & l) | (~d & (~en | e));
      wr(1'b0, pa({q[2], 1'b1}), d);
      wr(1'b0, pa({q[2], 1'b0}), l);
      rd(1'b0, pa({q[2], 1'b1}), d, d);
      rd(1'b0, pa({q[2], 1'b0}), x, x);
      chk(q[2] ? b_oe : a_oe, d);
      chk((q[2] ? b_out : a_out) & d, l & d);
    end
    for (int q = 0; q < 6; q++) begin
      v = 8'($urandom);
      ra = {rrc_pkg::DEF_RAM_HIGH, 6'($urandom)};
      wr(1'b0, ra, v);
      rd(1'b0, ra, v, v);
    end
    cpu_m.access(1'b1, 1'b0, {4'hF, 6'h00}, 8'h00, 8'h00, 8'h00, 1'b0);
    for (int q = 0; q < 4; q++) begin
      ra = 10'($urandom);
      v = ra[7:0] ^ rrc_pkg::DEF_ROM_SEED ^ {4{ra[9:8]}};
      wr(1'b1, ra, ~v);
      rd(1'b1, ra, v, v);
    end
    en_b = 8'h00;
    for (int s = 0; s < 4; s++) begin
      n = (s == 0) ? 20 : (s == 1) ? 5 : (s == 2) ? 3 : 1;
      p = (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 64 : 1024;
      wr(1'b0, ta(1'b1, 2'(s)), 8'(n));
      t = 0;
      if (p >= 64) begin
        repeat (p / 2) @(negedge sys_clk);
        rd(1'b0, ta(1'b1, 2'(s)), 8'(n), 8'(n));
        t = p / 2 + 2;
      end
      while (b_in[7] !== 1'b0 && t < 3000) begin
        @(negedge sys_clk);
        t++;
      end
      chk({7'h00, t >= n * p - 2 && t <= (n + 1) * p + 3}, 8'h01);
      chk({6'h00, b_oe[7], b_out[7]}, 8'h02);
      repeat (10) @(negedge sys_clk);
      rd(1'b0, ta(1'b1, 2'(s)), 8'hF0, 8'hF6);
      repeat (3) @(negedge sys_clk);
      chk({7'h00, b_in[7]}, 8'h01);
      rd(1'b0, ta(1'b0, 2'(s)), 8'hE6, 8'hF0);
      chk({7'h00, b_oe[7]}, 8'h00);
    end
    wr(1'b0, pa(rrc_pkg::SEL_PORT_A_DIR), 8'hFF);
    rst_b = 1'b0;
    @(negedge sys_clk);
    rst_b = 1'b1;
    chk(a_oe | {7'h00, data_oe}, 8'h00);
    rd(1'b0, pa(rrc_pkg::SEL_PORT_A_DIR), 8'h00, 8'h00);
    repeat (4) @(negedge sys_clk);
    chk(8'(cpu_m.exp_q.size()), 8'h00);
    final_report();
  end
endmodule
